// ---- include/dpw_pkg.sv ----
// constants shared by both ends of the wiper link and the host register map
// assumes a 20 MHz system clock on both ends
package dpw_pkg;
   localparam int CLK_NS = 50;
   // device type prefix; the value is arbitrary
   localparam logic [5:0] DEV_PREFIX = 6'h2a;
   localparam logic [7:0] WIPER_MID = 8'h80;
   localparam int INSTR_RS_BIT = 6;
   localparam int INSTR_SD_BIT = 5;
   // bus timing, least times in ns
   localparam int T_LOW_NS = 1300;
   localparam int T_HIGH_NS = 600;
   localparam int T_HD_STA_NS = 600;
   localparam int T_SU_STO_NS = 600;
   localparam int T_BUF_NS = 1300;
   localparam logic [5:0] LOW_HALF_CYC = 6'((T_LOW_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
   localparam logic [5:0] HIGH_CYC = 6'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] HD_STA_CYC = 6'((T_HD_STA_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] SU_STO_CYC = 6'((T_SU_STO_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] BUF_CYC = 6'((T_BUF_NS + CLK_NS - 1) / CLK_NS);
   // host register map
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_INSTR = 4'h4;
   localparam logic [3:0] REG_WDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   localparam int CMD_ASEL_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RDATA_LSB = 8;
   localparam logic [7:0] INSTR_RST = 8'h00;
   localparam logic [7:0] WDATA_RST = 8'h00;
endpackage

// ---- include/dpw_link_if.sv ----
// two-wire link between the bus master and the wiper slave
// both lines are open drain with a pull-up; a driver only pulls low
`timescale 1ns/1ps
interface dpw_link_if;
   logic scl_o;
   logic scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;

   assign scl = ~(~scl_oe_n & ~scl_o);
   assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

   modport master (output scl_o, output scl_oe_n, output m_sda_o, output m_sda_oe_n,
                   input scl, input sda);
   modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// ---- rtl/dpw_sync.sv ----
// three-stage input synchroniser with agreement filter
// assumes d is asynchronous to clk
`timescale 1ns/1ps
module dpw_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
      end
      else
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts once the last two stages agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= RST_VAL;
      end
      else if (s2 == s3)
      begin
         q <= s3;
      end
   end
endmodule

// ---- rtl/dpw_device.sv ----
// wiper slave: receives address, instruction and data bytes, holds the wiper code
// assumes the master drives the serial clock; lines arrive asynchronous to hclk
`timescale 1ns/1ps
module dpw_device (
   input wire logic hclk,
   input wire logic hresetn,
   dpw_link_if.slave link,
   input wire logic address_select_pin,
   output logic [7:0] wiper_position_register,
   output logic [255:0] wiper_tap,
   output logic top_terminal_open
);
   typedef enum logic [3:0] {
      S_IDLE,
      S_ADDR,
      S_ACK_ADDR,
      S_INSTR,
      S_ACK_INSTR,
      S_DATA,
      S_ACK_DATA,
      S_READ,
      S_READ_ACK,
      S_WAIT_STOP
   } dpw_dev_state_t;

   dpw_dev_state_t state;
   logic scl_q;
   logic sda_q;
   logic asel_q;
   logic scl_d;
   logic sda_d;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic mack;
   logic rs_seen;
   logic shutdown_bit;
   logic start_cond;
   logic stop_cond;
   logic scl_rise;
   logic scl_fall;
   logic addr_match;
   logic instr_done;
   logic data_done;

   function automatic logic [255:0] tap_onehot(input logic [7:0] code);
      tap_onehot = 256'h1 << code;
   endfunction

   dpw_sync #(.RST_VAL(1'b1)) u_scl (.clk(hclk), .rst_n(hresetn), .d(link.scl), .q(scl_q));
   dpw_sync #(.RST_VAL(1'b1)) u_sda (.clk(hclk), .rst_n(hresetn), .d(link.sda), .q(sda_q));
   dpw_sync #(.RST_VAL(1'b0)) u_asel
   (
      .clk(hclk),
      .rst_n(hresetn),
      .d(address_select_pin),
      .q(asel_q)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end

   assign start_cond = scl_q & scl_d & sda_d & ~sda_q;
   assign stop_cond = scl_q & scl_d & ~sda_d & sda_q;
   assign scl_rise = scl_q & ~scl_d;
   assign scl_fall = ~scl_q & scl_d;
   assign addr_match = (shreg[7:2] == dpw_pkg::DEV_PREFIX) && (shreg[1] == asel_q);
   assign instr_done = (state == S_ACK_INSTR) && scl_fall;
   assign data_done = (state == S_ACK_DATA) && scl_fall;

   // open drain: the data output only ever pulls low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link.s_sda_o <= 1'b0;
      end
      else
      begin
         link.s_sda_o <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= S_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         mack <= 1'b0;
         link.s_sda_oe_n <= 1'b1;
      end
      else if (start_cond)
      begin
         // a start, repeated or not, restarts address reception
         state <= S_ADDR;
         cnt <= 4'h0;
         link.s_sda_oe_n <= 1'b1;
      end
      else if (stop_cond)
      begin
         state <= S_IDLE;
         link.s_sda_oe_n <= 1'b1;
      end
      else
      begin
         unique case (state)
            S_IDLE, S_WAIT_STOP:
            begin
               link.s_sda_oe_n <= 1'b1;
            end
            S_ADDR, S_INSTR, S_DATA:
            begin
               if (scl_rise)
               begin
                  shreg <= {shreg[6:0], sda_q};
                  cnt <= cnt + 4'h1;
               end
               else if (scl_fall && cnt == 4'h8)
               begin
                  if (state == S_ADDR && !addr_match)
                  begin
                     state <= S_IDLE;
                  end
                  else
                  begin
                     link.s_sda_oe_n <= 1'b0;
                     state <= (state == S_ADDR) ? S_ACK_ADDR :
                              (state == S_INSTR) ? S_ACK_INSTR : S_ACK_DATA;
                  end
               end
            end
            S_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  cnt <= 4'h0;
                  if (shreg[0])
                  begin
                     state <= S_READ;
                     shreg <= wiper_position_register;
                     link.s_sda_oe_n <= wiper_position_register[7];
                  end
                  else
                  begin
                     state <= S_INSTR;
                     link.s_sda_oe_n <= 1'b1;
                  end
               end
            end
            S_ACK_INSTR, S_ACK_DATA:
            begin
               if (scl_fall)
               begin
                  // bytes past the data byte are taken as further wiper codes
                  state <= S_DATA;
                  cnt <= 4'h0;
                  link.s_sda_oe_n <= 1'b1;
               end
            end
            S_READ:
            begin
               if (scl_rise)
               begin
                  cnt <= cnt + 4'h1;
               end
               else if (scl_fall)
               begin
                  if (cnt == 4'h8)
                  begin
                     state <= S_READ_ACK;
                     link.s_sda_oe_n <= 1'b1;
                  end
                  else
                  begin
                     shreg <= {shreg[6:0], 1'b0};
                     link.s_sda_oe_n <= shreg[6];
                  end
               end
            end
            S_READ_ACK:
            begin
               if (scl_rise)
               begin
                  mack <= ~sda_q;
               end
               else if (scl_fall)
               begin
                  cnt <= 4'h0;
                  if (mack)
                  begin
                     state <= S_READ;
                     shreg <= wiper_position_register;
                     link.s_sda_oe_n <= wiper_position_register[7];
                  end
                  else
                  begin
                     state <= S_WAIT_STOP;
                     link.s_sda_oe_n <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // midscale request in this transfer blocks every data byte that follows it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rs_seen <= 1'b0;
      end
      else if (start_cond)
      begin
         rs_seen <= 1'b0;
      end
      else if (instr_done)
      begin
         rs_seen <= shreg[dpw_pkg::INSTR_RS_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wiper_position_register <= dpw_pkg::WIPER_MID;
      end
      else if (instr_done && shreg[dpw_pkg::INSTR_RS_BIT])
      begin
         wiper_position_register <= dpw_pkg::WIPER_MID;
      end
      else if (data_done && !rs_seen)
      begin
         wiper_position_register <= shreg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shutdown_bit <= 1'b0;
      end
      else if (instr_done)
      begin
         shutdown_bit <= shreg[dpw_pkg::INSTR_SD_BIT];
      end
   end

   // shutdown opens the top terminal and parks the wiper on the bottom tap
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wiper_tap <= tap_onehot(dpw_pkg::WIPER_MID);
         top_terminal_open <= 1'b0;
      end
      else
      begin
         wiper_tap <= tap_onehot(shutdown_bit ? 8'h00 : wiper_position_register);
         top_terminal_open <= shutdown_bit;
      end
   end
endmodule

// ---- rtl/dpw_host.sv ----
// bus master end: software orders a wiper write or read over AHB-Lite
// assumes a single AHB-Lite master; the slave end never stretches the clock
`timescale 1ns/1ps
module dpw_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   dpw_link_if.master link
);
   typedef enum logic [3:0] {
      H_IDLE,
      H_START,
      H_LO1,
      H_LO2,
      H_HI,
      H_STOP1,
      H_STOP2,
      H_STOP3,
      H_BUF
   } dpw_host_state_t;

   dpw_host_state_t state;
   logic sda_q;
   logic [5:0] timer;
   logic [3:0] bitn;
   logic [1:0] byten;
   logic [8:0] tx;
   logic [7:0] rx;
   logic rd;
   logic asel;
   logic busy;
   logic nack;
   logic [7:0] instr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic dp_wr;
   logic [3:0] dp_addr;
   logic go;
   logic ap_take;
   logic ap_ok;

   // byte k of a transfer; the read data slot is sent as all ones
   function automatic logic [7:0] byte_of(input logic [1:0] k, input logic r, input logic a);
      byte_of = (k == 2'd0) ? {dpw_pkg::DEV_PREFIX, a, r} :
                (k == 2'd1) ? (r ? 8'hff : instr) : wdata;
   endfunction

   dpw_sync #(.RST_VAL(1'b1)) u_sda (.clk(hclk), .rst_n(hresetn), .d(link.sda), .q(sda_q));

   assign ap_take = hsel & htrans[1] & hready;
   assign ap_ok = (haddr[31:4] == 28'h0) && (haddr[1:0] == 2'b00);
   assign go = dp_wr && dp_addr == dpw_pkg::REG_CMD && hwdata[dpw_pkg::CMD_GO_BIT] && !busy;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr <= 1'b0;
         dp_addr <= 4'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dp_wr <= ap_take & hwrite & ap_ok;
         dp_addr <= haddr[3:0];
         if (ap_take && !hwrite)
         begin
            hrdata <= 32'h0;
            if (ap_ok && haddr[3:0] == dpw_pkg::REG_INSTR)
            begin
               hrdata <= {24'h0, instr};
            end
            else if (ap_ok && haddr[3:0] == dpw_pkg::REG_WDATA)
            begin
               hrdata <= {24'h0, wdata};
            end
            else if (ap_ok && haddr[3:0] == dpw_pkg::REG_STATUS)
            begin
               hrdata <= {16'h0, rdata, 6'h0, nack, busy};
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         instr <= dpw_pkg::INSTR_RST;
         wdata <= dpw_pkg::WDATA_RST;
      end
      else if (dp_wr && dp_addr == dpw_pkg::REG_INSTR)
      begin
         instr <= hwdata[7:0];
      end
      else if (dp_wr && dp_addr == dpw_pkg::REG_WDATA)
      begin
         wdata <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link.scl_o <= 1'b0;
         link.m_sda_o <= 1'b0;
      end
      else
      begin
         link.scl_o <= 1'b0;
         link.m_sda_o <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= H_IDLE;
         timer <= 6'h0;
         bitn <= 4'h0;
         byten <= 2'd0;
         tx <= 9'h1ff;
         rx <= 8'h00;
         rd <= 1'b0;
         asel <= 1'b0;
         busy <= 1'b0;
         nack <= 1'b0;
         rdata <= 8'h00;
         link.scl_oe_n <= 1'b1;
         link.m_sda_oe_n <= 1'b1;
      end
      else if (state != H_IDLE && timer != 6'h0)
      begin
         timer <= timer - 6'h1;
      end
      else
      begin
         unique case (state)
            H_IDLE:
            begin
               if (go)
               begin
                  // start condition on an idle bus
                  rd <= hwdata[dpw_pkg::CMD_RD_BIT];
                  asel <= hwdata[dpw_pkg::CMD_ASEL_BIT];
                  tx <= {byte_of(2'd0, hwdata[dpw_pkg::CMD_RD_BIT],
                                 hwdata[dpw_pkg::CMD_ASEL_BIT]), 1'b1};
                  busy <= 1'b1;
                  nack <= 1'b0;
                  bitn <= 4'h0;
                  byten <= 2'd0;
                  link.m_sda_oe_n <= 1'b0;
                  timer <= dpw_pkg::HD_STA_CYC;
                  state <= H_START;
               end
            end
            H_START:
            begin
               link.scl_oe_n <= 1'b0;
               timer <= dpw_pkg::LOW_HALF_CYC;
               state <= H_LO1;
            end
            H_LO1:
            begin
               // data changes only while the clock is low
               link.m_sda_oe_n <= tx[8];
               timer <= dpw_pkg::LOW_HALF_CYC;
               state <= H_LO2;
            end
            H_LO2:
            begin
               link.scl_oe_n <= 1'b1;
               timer <= dpw_pkg::HIGH_CYC;
               state <= H_HI;
            end
            H_HI:
            begin
               link.scl_oe_n <= 1'b0;
               rx <= {rx[6:0], sda_q};
               tx <= {tx[7:0], 1'b1};
               timer <= dpw_pkg::LOW_HALF_CYC;
               if (bitn != 4'h8)
               begin
                  bitn <= bitn + 4'h1;
                  state <= H_LO1;
               end
               else if (sda_q && !(rd && byten == 2'd1))
               begin
                  nack <= 1'b1;
                  state <= H_STOP1;
               end
               else if (byten == (rd ? 2'd1 : 2'd2))
               begin
                  if (rd)
                  begin
                     rdata <= rx;
                  end
                  state <= H_STOP1;
               end
               else
               begin
                  bitn <= 4'h0;
                  byten <= byten + 2'd1;
                  tx <= {byte_of(byten + 2'd1, rd, asel), 1'b1};
                  state <= H_LO1;
               end
            end
            H_STOP1:
            begin
               link.m_sda_oe_n <= 1'b0;
               timer <= dpw_pkg::LOW_HALF_CYC;
               state <= H_STOP2;
            end
            H_STOP2:
            begin
               link.scl_oe_n <= 1'b1;
               timer <= dpw_pkg::SU_STO_CYC;
               state <= H_STOP3;
            end
            H_STOP3:
            begin
               link.m_sda_oe_n <= 1'b1;
               timer <= dpw_pkg::BUF_CYC;
               state <= H_BUF;
            end
            H_BUF:
            begin
               busy <= 1'b0;
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- test/dpw_sva.sv ----
// checker: protocol watch on the two-wire link between host and wiper device
// assumes hclk samples the resolved open-drain wires of the link interface
`timescale 1ns/1ps
module dpw_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic address_select_pin,
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_oe_n
);
   logic scl_q;
   logic sda_q;
   logic in_frame;
   logic [11:0] fcnt;
   logic [3:0] bcnt;
   logic [1:0] nbyte;
   logic [7:0] shreg;
   logic rd;
   logic miss;
   logic nacked;
   logic start_ev;
   logic stop_ev;
   logic rise;
   logic match;

   assign start_ev = scl && scl_q && sda_q && !sda;
   assign stop_ev = scl && scl_q && !sda_q && sda;
   assign rise = scl && !scl_q;
   assign match = shreg[7:2] == dpw_pkg::DEV_PREFIX && shreg[1] == address_select_pin;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // frame, bit and byte tracking from the wire levels alone
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_frame <= 1'b0;
         fcnt <= '0;
         bcnt <= '0;
         nbyte <= '0;
         shreg <= '0;
         rd <= 1'b0;
         miss <= 1'b0;
         nacked <= 1'b0;
      end
      else if (start_ev || stop_ev)
      begin
         in_frame <= start_ev;
         fcnt <= '0;
         bcnt <= '0;
         nbyte <= '0;
         rd <= 1'b0;
         miss <= 1'b0;
         nacked <= 1'b0;
      end
      else
      begin
         fcnt <= in_frame ? fcnt + 12'h1 : 12'h0;
         if (rise && bcnt != 4'h8)
            shreg <= {shreg[6:0], sda};
         if (rise)
            bcnt <= (bcnt == 4'h9) ? 4'h1 : bcnt + 4'h1;
         if (rise && bcnt == 4'h9 && nbyte != 2'h3)
            nbyte <= nbyte + 2'h1;
         if (rise && bcnt == 4'h8 && nbyte == 2'h0)
         begin
            rd <= shreg[0];
            miss <= !match;
         end
         if (rise && bcnt == 4'h8 && rd && sda)
            nacked <= 1'b1;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_ninth_rise;
      rise && in_frame && bcnt == 4'h8;
   endsequence

   AST_DEV_EDGE: assert property ($changed(s_sda_oe_n) |-> !scl)
      else $error("device changed data while clock high");
   AST_IDLE_RELEASE: assert property (!in_frame |-> s_sda_oe_n)
      else $error("device drove data outside a frame");
   AST_START_IDLE: assert property (start_ev |-> !in_frame)
      else $error("start seen while a frame was open");
   AST_ADDR_ACK: assert property (s_ninth_rise ##0 nbyte == 2'h0 |-> s_sda_oe_n == !match)
      else $error("address acknowledge does not follow the match");
   AST_MISS_RELEASE: assert property (miss |-> s_sda_oe_n)
      else $error("device drove data after an address mismatch");
   AST_WRITE_ACK: assert property (s_ninth_rise ##0 (nbyte != 2'h0 && !rd && !miss)
      |-> !s_sda_oe_n)
      else $error("written byte not acknowledged");
   AST_WRITE_QUIET: assert property (rise && in_frame && !rd && bcnt != 4'h8 |-> s_sda_oe_n)
      else $error("device drove data outside the ninth clock");
   AST_READ_RELEASE: assert property (s_ninth_rise ##0 rd |-> s_sda_oe_n)
      else $error("device held data during the master acknowledge");
   AST_NACK_RELEASE: assert property (nacked |-> s_sda_oe_n)
      else $error("device drove data after master withheld acknowledge");
   AST_FRAME_BOUND: assert property (in_frame |-> fcnt < 12'd1400)
      else $error("frame not closed by a stop in time");
endmodule

// ---- test/tb.sv ----
// bench: host and wiper device joined on one link, software side driven over AHB-Lite
// assumes the host register map and constants of dpw_pkg
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic asel_pin;
   logic [7:0] wiper;
   logic [255:0] tap;
   logic topen;
   int n_fail;
   int total_checks;
   int seed;

   dpw_link_if u_dpw_link_if();
   dpw_host u_dpw_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(u_dpw_link_if));
   dpw_device u_dpw_device(.hclk(hclk), .hresetn(hresetn), .link(u_dpw_link_if),
      .address_select_pin(asel_pin), .wiper_position_register(wiper), .wiper_tap(tap),
      .top_terminal_open(topen));
   dpw_sva u_dpw_sva(.hclk(hclk), .hresetn(hresetn), .address_select_pin(asel_pin),
      .scl(u_dpw_link_if.scl), .sda(u_dpw_link_if.sda),
      .s_sda_oe_n(u_dpw_link_if.s_sda_oe_n));

   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1)
      begin
         n_fail++;
         end_of_test();
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   // one link command, then poll until the host is no longer busy
   task automatic xfer(input logic rw, input logic a, input logic [7:0] ins,
      input logic [7:0] d, output logic [31:0] st);
      int n;
      ahb(1'b1, 32'(dpw_pkg::REG_INSTR), {24'h0, ins}, st);
      ahb(1'b1, 32'(dpw_pkg::REG_WDATA), {24'h0, d}, st);
      ahb(1'b1, 32'(dpw_pkg::REG_CMD), {29'h0, a, rw, 1'b1}, st);
      n = 0;
      do
      begin
         ahb(1'b0, 32'(dpw_pkg::REG_STATUS), 32'h0, st);
         n++;
      end
      while (st[dpw_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 2000);
      if (st[dpw_pkg::STAT_BUSY_BIT] !== 1'b0)
      begin
         n_fail++;
         end_of_test();
      end
   endtask

   function automatic logic [7:0] exp_wiper(logic [7:0] c, logic [7:0] ins, logic [7:0] d,
      logic m);
      if (!m)
         return c;
      return ins[dpw_pkg::INSTR_RS_BIT] ? dpw_pkg::WIPER_MID : d;
   endfunction

   initial
   begin
      logic [31:0] st;
      logic [7:0] cur;
      logic [7:0] d;
      logic [7:0] ins;
      logic sd;
      logic a;
      logic m;
      int i;
      seed = 32'h216a;
      n_fail = 0;
      total_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      asel_pin = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      `CHK("wiper", 8'h80, wiper)
      `CHK("tap", 256'h1 << 128, tap)
      `CHK("open", 1'b0, topen)
      @(posedge hclk);
      ahb(1'b1, 32'h14, 32'hff, st);
      ahb(1'b0, 32'h10, 32'h0, st);
      `CHK("unmapped", 32'h0, st)
      cur = dpw_pkg::WIPER_MID;
      sd = 1'b0;
      for (i = 0; i < 16; i++)
      begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         case (i)
            5: ins = 8'h40;
            6: ins = 8'h20;
            7: ins = 8'h80;
            default: ins = 8'($random(seed)) & 8'ha0;
         endcase
         a = 1'($random(seed));
         asel_pin <= a;
         m = (i % 5 != 4);
         xfer(1'b0, m ? a : !a, ins, d, st);
         if (m)
            sd = ins[dpw_pkg::INSTR_SD_BIT];
         cur = exp_wiper(cur, ins, d, m);
         `CHK("nack", !m, st[dpw_pkg::STAT_NACK_BIT])
         `CHK("wiper", cur, wiper)
         if (i == 5)
            `CHK("midscale", dpw_pkg::WIPER_MID, wiper)
         `CHK("open", sd, topen)
         `CHK("tap", sd ? 256'h1 : 256'h1 << cur, tap)
         xfer(1'b1, a, ins, d, st);
         `CHK("rdata", cur, st[15:8])
         `CHK("rnack", 1'b0, st[dpw_pkg::STAT_NACK_BIT])
         $display("test %0d done", i);
      end
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      `CHK("wiper", 8'h80, wiper)
      $display("test reset done");
      @(posedge hclk);
      end_of_test();
   end
endmodule
